// >>> rtl/sarref_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: classic wishbone, byte index times four is the byte address
// Notes:   definitions only
`ifndef SARREF_CFG_SVH
`define SARREF_CFG_SVH
// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define SARREF_IDX_REF_CTRL    8'h06
`define SARREF_IDX_RSVD_A      8'h07
`define SARREF_IDX_RSVD_B      8'h08
`define SARREF_IDX_TOUCH_STAT  8'h09
`define SARREF_IDX_AUX_STAT    8'h0a
`define SARREF_IDX_RSVD_C      8'h0b
`define SARREF_IDX_RSVD_D      8'h0c
`define SARREF_IDX_BUF_CTRL    8'h0d
`define SARREF_IDX_IRQ_STAT    8'h10
`define SARREF_IDX_IRQ_MASK    8'h11
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SARREF_BIT_REF_INT     7
`define SARREF_BIT_REF_HIGH    6
`define SARREF_BIT_REF_AUTO    5
`define SARREF_BIT_WAIT_HI     3
`define SARREF_BIT_WAIT_LO     2
`define SARREF_BIT_BAT_MODE    0
`define SARREF_BIT_BUF_EN      7
`define SARREF_RST_REF_CTRL    8'h20
`define SARREF_RST_RSVD        8'h00
`define SARREF_RST_TOUCH_RSVD  1'b0
`define SARREF_AUX_RSVD_MASK   8'h1c
// ----------------------------------------------------------------
// timing: waits are printed at an 8 mhz divided clock
// ----------------------------------------------------------------
`define SARREF_WAIT_CLK_KHZ    8000
`define SARREF_WAIT1_US        100
`define SARREF_WAIT2_US        500
`define SARREF_WAIT3_US        1000
`define SARREF_WAIT1_CYC       ((`SARREF_WAIT1_US * `SARREF_WAIT_CLK_KHZ) / 1000)
`define SARREF_WAIT2_CYC       ((`SARREF_WAIT2_US * `SARREF_WAIT_CLK_KHZ) / 1000)
`define SARREF_WAIT3_CYC       ((`SARREF_WAIT3_US * `SARREF_WAIT_CLK_KHZ) / 1000)
`define SARREF_SYNC_CLK_MHZ    50
`endif

// >>> rtl/sarref_pkg.sv
// Purpose: types shared by the reference and status block
// Assumes: sarref_cfg.svh holds the numbers
// Notes:   none
package sarref_pkg;
  typedef struct packed {
    logic       use_internal;
    logic       level_high;
    logic       auto_power;
    logic [1:0] wait_code;
    logic       battery_mode;
  } sarref_ref_cfg_t;

  typedef struct packed {
    logic x;
    logic y;
    logic pressure_one;
    logic pressure_two;
    logic aux_input_one;
    logic aux_input_two;
    logic battery_pin;
    logic temperature_one;
    logic temperature_two;
  } sarref_chan_t;

  typedef enum logic [1:0] {
    SARREF_IDLE   = 2'b00,
    SARREF_SETTLE = 2'b01,
    SARREF_GO     = 2'b10
  } sarref_state_t;
endpackage : sarref_pkg

// >>> rtl/sarref_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: input is asynchronous to clk_sys_in
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module sarref_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  // data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule : sarref_sync

// >>> rtl/sarref_flag.sv
// Purpose: sticky new-data flag, set by hardware, cleared by a read
// Assumes: set and clear are single-cycle pulses on clk_sys_in
// Notes:   set wins over clear so no event is lost
`timescale 1ns/100ps
module sarref_flag (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  // control
  input  wire logic set_in,
  input  wire logic clr_in,
  input  wire logic flush_in,
  output logic      flag_out
);
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clr_in || flush_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule : sarref_flag

// >>> rtl/sarref_top.sv
// Purpose: sar reference control and conversion status registers
// Assumes: classic wishbone slave, 32-bit data, single clock
// Notes:   conversion sequencer and result storage live outside
//
// Overview of operation
// - reference-select bit: 0 external reference, 1 internal, reset 0.
// - reference-level bit: 0 gives 1.25 V internal level, 1 gives 2.5 V, reset 0.
// - auto-power bit, reset 1, gates the internal reference with conversions; 0 keeps it on.
// - two-bit settle field: 00 none, 01 100 us, 10 500 us, 11 1 ms, reset 00.
// - settle waits are counted in divided-clock cycles, 8 MHz nominal, scaling with it.
// - battery-mode bit: 0 battery input is a plain auxiliary input, 1 measures the battery.
// - read-only pen-touch bit reads 1 while touched, reset 0.
// - read-only bit reads 0 while the converter is busy, 1 when idle, reset 1.
// - summary new-data flag sets on results and clears only when all are read.
// - x, y, pressure-one and pressure-two flags sit at bits 3..0, each cleared by its read.
// - aux one, aux two, battery, temperature one and two flags sit at bits 7,6,5,1,0.
// - a buffer-enable bit marks flags invalid; clearing it resets the buffer pointers.
`timescale 1ns/100ps
`include "sarref_cfg.svh"
module sarref_top
  import sarref_pkg::*;
#(
  parameter int DIV_CLK_KHZ = `SARREF_WAIT_CLK_KHZ,
  parameter int WAIT1_CYC   = `SARREF_WAIT1_CYC,
  parameter int WAIT2_CYC   = `SARREF_WAIT2_CYC,
  parameter int WAIT3_CYC   = `SARREF_WAIT3_CYC
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             wb_err_out,
  // divided master clock tick, one pulse per divided period
  input  wire logic        div_tick_in,
  // sequencer
  input  wire logic        conv_req_in,
  output logic             conv_go_out,
  input  wire logic        conv_busy_in,
  input  wire sarref_chan_t stored_in,
  input  wire sarref_chan_t read_in,
  // pen pin
  input  wire logic        pen_touch_in,
  // analog controls
  output sarref_ref_cfg_t  ref_cfg_out,
  output logic             ref_power_out,
  output logic             buffer_enable_out,
  output logic             buffer_ptr_reset_out,
  // interrupt
  output logic             irq_out
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]      ref_ctrl_r;
  logic [7:0]      rsvd_a_r;
  logic [7:0]      rsvd_b_r;
  logic [7:0]      rsvd_c_r;
  logic [7:0]      rsvd_d_r;
  logic            touch_rsvd_r;
  logic [2:0]      aux_rsvd_r;
  logic            buf_en_r;
  logic [1:0]      irq_stat_r;
  logic [1:0]      irq_mask_r;
  logic            ack_r;
  logic [31:0]     rdata_r;
  sarref_state_t   state_r;
  sarref_state_t   state_nxt;
  logic [15:0]     wait_cnt_r;
  logic [15:0]     wait_cnt_nxt;
  logic            pen_sync;
  logic            pen_prev_r;
  sarref_chan_t    flags;
  logic            summary_flag;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        req        = wb_cyc_in && wb_stb_in && !ack_r;
  wire        wr_lane0   = req && wb_we_in && wb_sel_in[0];
  wire        rd_req     = req && !wb_we_in;
  wire [7:0]  idx        = {2'b00, wb_adr_in[7:2]};
  wire        hit_ref    = (idx == `SARREF_IDX_REF_CTRL);
  wire        hit_rsvd_a = (idx == `SARREF_IDX_RSVD_A);
  wire        hit_rsvd_b = (idx == `SARREF_IDX_RSVD_B);
  wire        hit_touch  = (idx == `SARREF_IDX_TOUCH_STAT);
  wire        hit_aux    = (idx == `SARREF_IDX_AUX_STAT);
  wire        hit_rsvd_c = (idx == `SARREF_IDX_RSVD_C);
  wire        hit_rsvd_d = (idx == `SARREF_IDX_RSVD_D);
  wire        hit_buf    = (idx == `SARREF_IDX_BUF_CTRL);
  wire        hit_istat  = (idx == `SARREF_IDX_IRQ_STAT);
  wire        hit_imask  = (idx == `SARREF_IDX_IRQ_MASK);
  wire        hit_any    = hit_ref || hit_rsvd_a || hit_rsvd_b || hit_touch || hit_aux
                           || hit_rsvd_c || hit_rsvd_d || hit_buf || hit_istat || hit_imask;
  wire [7:0]  wbyte      = wb_dat_in[7:0];

  // ----------------------------------------------------------------
  // pen input passes a synchroniser
  // ----------------------------------------------------------------
  sarref_sync #(
    .WIDTH (1)
  ) u_pen_sync (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .d_in       (pen_touch_in),
    .q_out      (pen_sync)
  );

  // ----------------------------------------------------------------
  // new-data flags
  // ----------------------------------------------------------------
  // flags only track results outside buffer mode
  wire [8:0] flag_set   = buf_en_r ? 9'h000 : stored_in;
  wire [8:0] flag_clr   = read_in;
  wire       buf_flush  = wr_lane0 && hit_buf && !wbyte[`SARREF_BIT_BUF_EN];

  genvar g;
  generate
    for (g = 0; g < 9; g++) begin : g_flag
      sarref_flag u_flag (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .set_in     (flag_set[g]),
        .clr_in     (flag_clr[g]),
        .flush_in   (1'b0),
        .flag_out   (flags[g])
      );
    end
  endgenerate

  // summary stays up until every channel result has been read
  assign summary_flag = |flags;

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  wire [7:0] touch_view = {pen_sync,
                           !conv_busy_in,
                           summary_flag,
                           touch_rsvd_r,
                           flags.x, flags.y, flags.pressure_one,
                           flags.pressure_two};
  wire [7:0] aux_view   = {flags.aux_input_one, flags.aux_input_two,
                           flags.battery_pin, aux_rsvd_r,
                           flags.temperature_one, flags.temperature_two};

  wire [7:0] rd_byte =
      hit_ref    ? ref_ctrl_r :
      hit_rsvd_a ? rsvd_a_r :
      hit_rsvd_b ? rsvd_b_r :
      hit_touch  ? touch_view :
      hit_aux    ? aux_view :
      hit_rsvd_c ? rsvd_c_r :
      hit_rsvd_d ? rsvd_d_r :
      hit_buf    ? {buf_en_r, 7'h00} :
      hit_istat  ? {6'h00, irq_stat_r} :
      hit_imask  ? {6'h00, irq_mask_r} :
                   8'h00;

  // ----------------------------------------------------------------
  // settle timer before each conversion
  // ----------------------------------------------------------------
  // counts divided-clock ticks, so waits scale with the divided rate
  wire [15:0] wait_len =
      (ref_ctrl_r[3:2] == 2'b01) ? 16'(WAIT1_CYC) :
      (ref_ctrl_r[3:2] == 2'b10) ? 16'(WAIT2_CYC) :
      (ref_ctrl_r[3:2] == 2'b11) ? 16'(WAIT3_CYC) :
                                   16'h0000;

  always_comb begin
    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    conv_go_out  = 1'b0;
    case (state_r)
      SARREF_IDLE: begin
        if (conv_req_in) begin
          wait_cnt_nxt = wait_len;
          state_nxt    = (wait_len == 16'h0000) ? SARREF_GO : SARREF_SETTLE;
        end
      end
      SARREF_SETTLE: begin
        if (div_tick_in) begin
          wait_cnt_nxt = wait_cnt_r - 16'h0001;
          if (wait_cnt_r == 16'h0001) begin
            state_nxt = SARREF_GO;
          end
        end
      end
      SARREF_GO: begin
        conv_go_out = 1'b1;
        state_nxt   = SARREF_IDLE;
      end
      default: begin
        state_nxt = SARREF_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // analog controls
  // ----------------------------------------------------------------
  assign ref_cfg_out.use_internal = ref_ctrl_r[`SARREF_BIT_REF_INT];
  assign ref_cfg_out.level_high   = ref_ctrl_r[`SARREF_BIT_REF_HIGH];
  assign ref_cfg_out.auto_power   = ref_ctrl_r[`SARREF_BIT_REF_AUTO];
  assign ref_cfg_out.wait_code    = ref_ctrl_r[`SARREF_BIT_WAIT_HI:`SARREF_BIT_WAIT_LO];
  assign ref_cfg_out.battery_mode = ref_ctrl_r[`SARREF_BIT_BAT_MODE];
  // the reference also settles while powered ahead of a conversion
  assign ref_power_out = !ref_ctrl_r[`SARREF_BIT_REF_AUTO] || conv_busy_in
                         || (state_r != SARREF_IDLE);
  assign buffer_enable_out    = buf_en_r;
  assign buffer_ptr_reset_out = !buf_en_r;

  // ----------------------------------------------------------------
  // interrupts: bit0 new data, bit1 pen down
  // ----------------------------------------------------------------
  wire       pen_rise  = pen_sync && !pen_prev_r;
  wire [1:0] irq_event = {pen_rise, |flag_set};
  wire [1:0] irq_w1c   = (wr_lane0 && hit_istat) ? wbyte[1:0] : 2'b00;
  assign irq_out    = |(irq_stat_r & irq_mask_r);
  assign wb_ack_out = ack_r;
  assign wb_err_out = 1'b0;
  assign wb_dat_out = rdata_r;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r    <= SARREF_IDLE;
      wait_cnt_r <= 16'h0000;
      pen_prev_r <= 1'b0;
      irq_stat_r <= 2'b00;
      ack_r      <= 1'b0;
      rdata_r    <= 32'h0000_0000;
    end else begin
      state_r    <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      pen_prev_r <= pen_sync;
      // set wins over the write-one clear
      irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_event;
      ack_r      <= req;
      rdata_r    <= rd_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // reserved registers just hold what software writes; only reset values are expected
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_ctrl_r   <= `SARREF_RST_REF_CTRL;
      rsvd_a_r     <= `SARREF_RST_RSVD;
      rsvd_b_r     <= `SARREF_RST_RSVD;
      rsvd_c_r     <= `SARREF_RST_RSVD;
      rsvd_d_r     <= `SARREF_RST_RSVD;
      touch_rsvd_r <= `SARREF_RST_TOUCH_RSVD;
      aux_rsvd_r   <= 3'b000;
      buf_en_r     <= 1'b0;
      irq_mask_r   <= 2'b00;
    end else if (wr_lane0) begin
      if (hit_ref) begin
        ref_ctrl_r <= wbyte;
      end else if (hit_rsvd_a) begin
        rsvd_a_r <= wbyte;
      end else if (hit_rsvd_b) begin
        rsvd_b_r <= wbyte;
      end else if (hit_rsvd_c) begin
        rsvd_c_r <= wbyte;
      end else if (hit_rsvd_d) begin
        rsvd_d_r <= wbyte;
      end else if (hit_touch) begin
        touch_rsvd_r <= wbyte[4];
      end else if (hit_aux) begin
        aux_rsvd_r <= wbyte[4:2];
      end else if (hit_buf) begin
        buf_en_r <= !buf_flush;
      end else if (hit_imask) begin
        irq_mask_r <= wbyte[1:0];
      end
    end
  end
endmodule : sarref_top

// >>> verification/sarref_top_asserts.sv
// Purpose: port-level checks on sarref_top
// Assumes: single clock, asynchronous active-low reset
// Notes:   a write lands at the edge that launches ack
`timescale 1ns/100ps
`include "sarref_cfg.svh"
module sarref_top_asserts
  import sarref_pkg::*;
#(
  parameter int DIV_CLK_KHZ = `SARREF_WAIT_CLK_KHZ,
  parameter int WAIT1_CYC   = `SARREF_WAIT1_CYC,
  parameter int WAIT2_CYC   = `SARREF_WAIT2_CYC,
  parameter int WAIT3_CYC   = `SARREF_WAIT3_CYC
) (
  // clock and reset
  input wire logic            clk_sys_in,
  input wire logic            rst_b_in,
  // bus
  input wire logic            wb_cyc_in,
  input wire logic            wb_stb_in,
  input wire logic            wb_we_in,
  input wire logic [7:0]      wb_adr_in,
  input wire logic [3:0]      wb_sel_in,
  input wire logic [31:0]     wb_dat_in,
  input wire logic [31:0]     wb_dat_out,
  input wire logic            wb_ack_out,
  // conversion and reference
  input wire logic            conv_req_in,
  input wire logic            conv_go_out,
  input wire logic            conv_busy_in,
  input wire sarref_ref_cfg_t ref_cfg_out,
  input wire logic            ref_power_out,
  input wire logic            buffer_enable_out,
  input wire logic            buffer_ptr_reset_out,
  input wire logic            irq_out
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  wire take   = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire ref_wr = take && wb_we_in && wb_sel_in[0] && wb_adr_in[7:2] == 6'h06;
  // direction of the request being answered, kept in clocked helper logic
  logic we_d_r;
  always_ff @(posedge clk_sys_in) begin
    we_d_r <= wb_we_in;
  end
  wire rd_ack = wb_ack_out && !we_d_r;
  a_ack_one_wait: assert property (take |=> wb_ack_out)
    else $error("ack did not follow a taken request");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  a_dat_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data not zero outside ack");
  a_ref_write: assert property (ref_wr |=>
    ref_cfg_out == {$past(wb_dat_in[7:5]), $past(wb_dat_in[3:2]), $past(wb_dat_in[0])})
    else $error("reference control did not take written value");
  a_ref_readback: assert property (rd_ack && $past(wb_adr_in[7:2]) == 6'h06 |->
    {wb_dat_out[7:5], wb_dat_out[3:2], wb_dat_out[0]} == ref_cfg_out)
    else $error("reference control read back wrong");
  a_busy_bit: assert property (rd_ack && $past(wb_adr_in[7:2]) == 6'h09 |->
    wb_dat_out[6] == !$past(conv_busy_in))
    else $error("idle bit does not mirror busy");
  a_ptr_reset_inv: assert property (buffer_ptr_reset_out == !buffer_enable_out)
    else $error("pointer reset not inverse of buffer enable");
  a_go_pulse: assert property (conv_go_out |=> !conv_go_out)
    else $error("conversion start longer than one cycle");
  a_go_no_wait: assert property (conv_go_out && ref_cfg_out.wait_code == 2'b00 |->
    $past(conv_req_in))
    else $error("zero-wait start not one cycle after request");
  a_ref_power_on: assert property (!ref_cfg_out.auto_power || conv_busy_in |->
    ref_power_out)
    else $error("reference unpowered while required");
  c_ref_write: cover property (ref_wr);
  c_go: cover property (conv_go_out);
  c_buffer: cover property ($rose(buffer_enable_out));
  c_irq: cover property ($rose(irq_out));
endmodule : sarref_top_asserts

bind sarref_top sarref_top_asserts #(.DIV_CLK_KHZ(DIV_CLK_KHZ), .WAIT1_CYC(WAIT1_CYC),
  .WAIT2_CYC(WAIT2_CYC), .WAIT3_CYC(WAIT3_CYC)) u_asserts (.*);

// >>> verification/testbench.sv
// Purpose: self-checking bench for sarref_top
// Assumes: settle waits shortened to 3/5/7 divided-clock ticks
// Notes:   tick runs every other cycle so counts are unambiguous
`timescale 1ns/100ps
`include "sarref_cfg.svh"
module testbench;
  import sarref_pkg::*;
  localparam int W1 = 3, W2 = 5, W3 = 7;
  logic clk_sys_in = 1'b0, rst_b_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic tick = 1'b0, req = 1'b0, busy = 1'b0, pen = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_out;
  logic ack, go, pwr, ben, prst, irq, err;
  sarref_chan_t st = '0, rd = '0;
  sarref_ref_cfg_t cfg;
  int n_errors = 0, samples_checked = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) tick <= ~tick;
  sarref_top #(.WAIT1_CYC(W1), .WAIT2_CYC(W2), .WAIT3_CYC(W3)) dut (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dat_out),
    .wb_ack_out(ack), .wb_err_out(err), .div_tick_in(tick), .conv_req_in(req),
    .conv_go_out(go), .conv_busy_in(busy), .stored_in(st), .read_in(rd),
    .pen_touch_in(pen), .ref_cfg_out(cfg), .ref_power_out(pwr), .buffer_enable_out(ben),
    .buffer_ptr_reset_out(prst), .irq_out(irq));
  // ----------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("counts: %0d checked, %0d mismatches", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      n_errors++;
    end
  endtask : chk
  // no fixed latency assumed: wait for ack under a bound
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] s = 4'h1);
    int k;
    k = 0;
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx[5:0], 2'b00};
    sel <= s;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    rdat = dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic pulse(input logic [8:0] m, input logic r);
    @(posedge clk_sys_in);
    if (r) rd <= sarref_chan_t'(m);
    else st <= sarref_chan_t'(m);
    @(posedge clk_sys_in);
    rd <= '0;
    st <= '0;
  endtask : pulse
  function automatic logic [31:0] ex_t(input logic [8:0] m);
    return {24'h0, pen, ~busy, |m, 1'b0, m[8:5]};
  endfunction : ex_t
  function automatic logic [31:0] ex_a(input logic [8:0] m);
    return {24'h0, m[4:2], 3'b000, m[1:0]};
  endfunction : ex_a
  function automatic logic [31:0] ex_w(input int c);
    return (c == 0) ? 0 : (c == 1) ? W1 : (c == 2) ? W2 : W3;
  endfunction : ex_w
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] rsv [4];
    int n;
    rsv = '{`SARREF_IDX_RSVD_A, `SARREF_IDX_RSVD_B, `SARREF_IDX_RSVD_C, `SARREF_IDX_RSVD_D};
    void'($urandom(45079));
    repeat (2) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    bus(0, `SARREF_IDX_REF_CTRL, 8'h00);
    chk(rdat, 32'h20);
    chk(32'(cfg), 32'h08);
    chk(32'(err), 32'h0);
    bus(0, `SARREF_IDX_TOUCH_STAT, 8'h00);
    chk(rdat, ex_t(9'h0));
    bus(0, `SARREF_IDX_AUX_STAT, 8'h00);
    chk(rdat, ex_a(9'h0));
    foreach (rsv[i]) begin
      bus(1, rsv[i], 8'h00);
      bus(0, rsv[i], 8'h00);
      chk(rdat, 32'h0);
    end
    bus(1, 8'h3f, 8'hff);
    bus(0, 8'h3f, 8'h00);
    chk(rdat, 32'h0);
    $display("test reset and map done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom()) & 8'hed;
      d[3:2] = 2'(i);
      bus(1, `SARREF_IDX_REF_CTRL, d);
      bus(0, `SARREF_IDX_REF_CTRL, 8'h00);
      chk(rdat, {24'h0, d});
      chk(32'(cfg), 32'({d[7:5], d[3:2], d[0]}));
      chk(32'(pwr), 32'(!d[5]));
    end
    bus(1, `SARREF_IDX_REF_CTRL, 8'hff, 4'h0);
    bus(0, `SARREF_IDX_REF_CTRL, 8'h00);
    chk(rdat, {24'h0, d});
    $display("test reference control done");
    for (int w = 0; w < 4; w++) begin
      bus(1, `SARREF_IDX_REF_CTRL, 8'(8'h20 | (w << 2)));
      @(posedge clk_sys_in);
      if (tick !== 1'b1) @(posedge clk_sys_in);
      req <= 1'b1;
      @(posedge clk_sys_in);
      req <= 1'b0;
      n = 0;
      for (int k = 0; k < 100; k++) begin
        @(posedge clk_sys_in);
        if (go === 1'b1) break;
        if (tick === 1'b1) n++;
        if (k == 0 && w != 0) chk(32'(pwr), 32'h1);
      end
      chk(32'(n), ex_w(w));
    end
    $display("test settle wait done");
    for (int i = 0; i < 9; i++) begin
      pulse(9'(1 << i), 1'b0);
      bus(0, `SARREF_IDX_TOUCH_STAT, 8'h00);
      chk(rdat, ex_t(9'(1 << i)));
      bus(0, `SARREF_IDX_AUX_STAT, 8'h00);
      chk(rdat, ex_a(9'(1 << i)));
      pulse(9'(1 << i), 1'b1);
      bus(0, `SARREF_IDX_TOUCH_STAT, 8'h00);
      chk(rdat, ex_t(9'h0));
      bus(0, `SARREF_IDX_AUX_STAT, 8'h00);
      chk(rdat, ex_a(9'h0));
    end
    pulse(9'h180, 1'b0);
    pulse(9'h100, 1'b1);
    bus(0, `SARREF_IDX_TOUCH_STAT, 8'h00);
    chk(rdat, ex_t(9'h080));
    pulse(9'h080, 1'b1);
    bus(1, `SARREF_IDX_AUX_STAT, 8'h00);
    bus(0, `SARREF_IDX_AUX_STAT, 8'h00);
    chk(rdat, ex_a(9'h0));
    bus(1, `SARREF_IDX_BUF_CTRL, 8'h80);
    chk({30'h0, ben, prst}, 32'h2);
    pulse(9'h1ff, 1'b0);
    bus(0, `SARREF_IDX_TOUCH_STAT, 8'h00);
    chk(rdat, ex_t(9'h0));
    bus(1, `SARREF_IDX_BUF_CTRL, 8'h00);
    chk({30'h0, ben, prst}, 32'h1);
    $display("test new-data flags done");
    bus(1, `SARREF_IDX_IRQ_STAT, 8'hff);
    bus(1, `SARREF_IDX_IRQ_MASK, 8'h00);
    pulse(9'h001, 1'b0);
    bus(0, `SARREF_IDX_IRQ_STAT, 8'h00);
    chk(rdat, 32'h1);
    chk(32'(irq), 32'h0);
    bus(1, `SARREF_IDX_IRQ_MASK, 8'h01);
    bus(0, `SARREF_IDX_IRQ_MASK, 8'h00);
    chk(rdat, 32'h1);
    chk(32'(irq), 32'h1);
    bus(1, `SARREF_IDX_IRQ_STAT, 8'h01);
    bus(0, `SARREF_IDX_IRQ_STAT, 8'h00);
    chk(rdat, 32'h0);
    chk(32'(irq), 32'h0);
    pulse(9'h001, 1'b1);
    pen <= 1'b1;
    busy <= 1'b1;
    bus(1, `SARREF_IDX_IRQ_MASK, 8'h02);
    bus(0, `SARREF_IDX_TOUCH_STAT, 8'h00);
    chk(rdat, ex_t(9'h0));
    chk(32'(irq), 32'h1);
    chk(32'(pwr), 32'h1);
    $display("test interrupt and pen done");
    end_sim();
  end
endmodule : testbench
